// ==== rtl/dlf_regs.svh ====
// Register offsets, field positions, reset values and fixed counts of the
// display line fetch block. Assumes the byte addresses of a 16-bit window.
`ifndef DLF_REGS_SVH
`define DLF_REGS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DLF_LINE_STRIDE_OFS 16'h8324
`define DLF_BUF_SIZE_OFS 16'h8328
`define DLF_RSVD_OFS 16'h832c
`define DLF_HTIME_OFS 16'h8330
`define DLF_HSYNC_OFS 16'h8334
`define DLF_VTIME_OFS 16'h8338
`define DLF_VSYNC_OFS 16'h833c
`define DLF_CB_ORIGIN_OFS 16'h8380
`define DLF_FB_ORIGIN_OFS 16'h8384
`define DLF_CTRL_OFS 16'h8388
`define DLF_IRQ_STAT_OFS 16'h838c
`define DLF_IRQ_MASK_OFS 16'h8390
// ----------------------------------------------------------------------
// Field positions and limits
// ----------------------------------------------------------------------
`define DLF_CB_STRIDE 21:12
`define DLF_FB_STRIDE 9:0
`define DLF_VIDBUF_LEN 29:16
`define DLF_CB_LEN 15:9
`define DLF_FB_QWORDS 8:0
`define DLF_H_HI 26:19
`define DLF_H_LO 10:3
`define DLF_V_HI 26:16
`define DLF_V_LO 10:0
`define DLF_ORIGIN 21:0
`define DLF_CB_LEN_MAX 7'h41
`define DLF_PIX_PER_CHAR 8
`define DLF_RESET_WORD 32'h0000_0000
`endif

// ==== rtl/dlf_pkg.sv ====
// Types shared by the display line fetch block and its bench.
// Assumes the constants header is compiled alongside.
package dlf_pkg;
    // Burst read request toward the memory controller
    typedef struct packed {
        logic [21:0] addr;
        logic [8:0] qwords;
    } dlf_mem_req_t;
    // Display raster outputs
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic blank;
        logic field;
    } dlf_raster_t;
    typedef enum logic [1:0] {DLF_IRQ_OVF, DLF_IRQ_FRAME, DLF_IRQ_CFG} dlf_irq_bit_t;
endpackage

// ==== rtl/dlf_line_fetch.sv ====
// Display line fetch: raster timing, per-line frame buffer and compressed
// buffer pointers, QWORD burst fetch and compressed FIFO overflow check.
// Assumes one clock, an AXI4-Lite master and a memory controller that
// returns one QWORD beat per mem_beat_valid after a taken request.
// How it works
// R1 - Compressed line start is previous start plus stride DWORDs, 10-bit field.
// R2 - Frame buffer line start is previous start plus 10-bit DWORD stride.
// R3 - 14-bit video buffer length counts 64-byte segments, up to 1 MB.
// R4 - 7-bit compressed line length holds valid DWORD count plus one.
// R5 - Length detects compressed FIFO overflow; software keeps it at most 41h.
// R6 - Each line fetches the programmed 9-bit count of QWORDs; a line whose start finds a burst still running fetches nothing.
// R7 - Surplus QWORDs fetched beyond the line end are dropped.
// R8 - Horizontal timing counts character clocks of 8 pixels.
// R9 - Interlaced mode steps the vertical counter by two per line.
// R10 - Software programs interlaced vertical timing for the whole frame.
// R11 - Sync, blank and active region come from the timing registers.
// R12 - One programmable timing set serves CRT and flat panel alike.
// R13 - Compressed pointer starts from a 22-bit, 16-byte aligned origin.
// R14 - Each frame reloads both pointers from origins before any stride.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`include "dlf_regs.svh"
module dlf_line_fetch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mem_req_valid,
    output dlf_pkg::dlf_mem_req_t mem_req,
    input wire logic mem_req_ready,
    input wire logic mem_beat_valid,
    input wire logic [63:0] mem_beat_data,
    output logic pix_valid,
    output logic [63:0] pix_data,
    output logic [21:0] cb_line_addr,
    input wire logic cb_dword_valid,
    output logic [19:0] video_buffer_bytes,
    output dlf_pkg::dlf_raster_t raster,
    output logic irq
);
    import dlf_pkg::*;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [31:0] line_stride, buffer_and_line_size;
    logic [31:0] htime, hsync_pos, vtime, vsync_pos;
    logic [31:0] cb_origin, fb_origin, ctrl, irq_mask;
    logic [2:0] irq_stat, irq_set;
    logic aw_held, w_held;
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go, wr_hit, rd_hit;
    logic [31:0] rd_word;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    // Address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 16'h0000;
            w_data <= `DLF_RESET_WORD;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = w_strb[i] ? w_data[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    always_comb begin
        unique case (aw_addr)
            `DLF_LINE_STRIDE_OFS, `DLF_BUF_SIZE_OFS, `DLF_RSVD_OFS, `DLF_HTIME_OFS,
            `DLF_HSYNC_OFS, `DLF_VTIME_OFS, `DLF_VSYNC_OFS, `DLF_CB_ORIGIN_OFS,
            `DLF_FB_ORIGIN_OFS, `DLF_CTRL_OFS, `DLF_IRQ_STAT_OFS,
            `DLF_IRQ_MASK_OFS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Configuration registers; reserved bits are never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_stride <= `DLF_RESET_WORD;
            buffer_and_line_size <= `DLF_RESET_WORD;
            htime <= `DLF_RESET_WORD;
            hsync_pos <= `DLF_RESET_WORD;
            vtime <= `DLF_RESET_WORD;
            vsync_pos <= `DLF_RESET_WORD;
            cb_origin <= `DLF_RESET_WORD;
            fb_origin <= `DLF_RESET_WORD;
            ctrl <= `DLF_RESET_WORD;
            irq_mask <= `DLF_RESET_WORD;
        end else if (wr_go) begin
            unique case (aw_addr)
                `DLF_LINE_STRIDE_OFS: line_stride <= merge(line_stride) & 32'h003f_f3ff;
                `DLF_BUF_SIZE_OFS: buffer_and_line_size <= merge(buffer_and_line_size) & 32'h3fff_ffff;
                `DLF_HTIME_OFS: htime <= merge(htime) & 32'h07f8_07f8;
                `DLF_HSYNC_OFS: hsync_pos <= merge(hsync_pos) & 32'h07f8_07f8;
                `DLF_VTIME_OFS: vtime <= merge(vtime) & 32'h07ff_07ff;
                `DLF_VSYNC_OFS: vsync_pos <= merge(vsync_pos) & 32'h07ff_07ff;
                // Low four bits forced clear: origin is 16-byte aligned [R13]
                `DLF_CB_ORIGIN_OFS: cb_origin <= merge(cb_origin) & 32'h003f_fff0;
                `DLF_FB_ORIGIN_OFS: fb_origin <= merge(fb_origin) & 32'h003f_fff8;
                `DLF_CTRL_OFS: ctrl <= merge(ctrl) & 32'h0000_0003;
                `DLF_IRQ_MASK_OFS: irq_mask <= merge(irq_mask) & 32'h0000_0007;
                default: ;
            endcase
        end
    end

    // Write response follows both halves; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `DLF_LINE_STRIDE_OFS: rd_word = line_stride;
            `DLF_BUF_SIZE_OFS: rd_word = buffer_and_line_size;
            `DLF_RSVD_OFS: rd_word = `DLF_RESET_WORD;
            `DLF_HTIME_OFS: rd_word = htime;
            `DLF_HSYNC_OFS: rd_word = hsync_pos;
            `DLF_VTIME_OFS: rd_word = vtime;
            `DLF_VSYNC_OFS: rd_word = vsync_pos;
            `DLF_CB_ORIGIN_OFS: rd_word = cb_origin;
            `DLF_FB_ORIGIN_OFS: rd_word = fb_origin;
            `DLF_CTRL_OFS: rd_word = ctrl;
            `DLF_IRQ_STAT_OFS: rd_word = {29'h0, irq_stat};
            `DLF_IRQ_MASK_OFS: rd_word = irq_mask;
            default: begin
                rd_word = `DLF_RESET_WORD;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `DLF_RESET_WORD;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Raster timing
    // ------------------------------------------------------------------
    logic enable, interlace;
    logic [2:0] pix_cnt;
    logic char_en, line_start, frame_start;
    logic [7:0] hcnt;
    logic [10:0] vcnt, vstep;
    logic line_active;

    assign enable = ctrl[0];
    assign interlace = ctrl[1];
    assign char_en = enable && (pix_cnt == 3'(`DLF_PIX_PER_CHAR - 1)); // [R8]
    assign line_start = char_en && (hcnt == htime[`DLF_H_HI]);
    assign vstep = interlace ? 11'd2 : 11'd1; // [R9]
    assign frame_start = line_start && (vcnt + vstep > vtime[`DLF_V_HI]);
    assign line_active = (vcnt <= vtime[`DLF_V_LO]);

    // Pixel divider: one character clock every eight pixels
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            pix_cnt <= 3'h0;
        end else begin
            pix_cnt <= pix_cnt + 3'h1;
        end
    end

    // Counters run in whole-frame terms so one set fits CRT and panels [R12]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hcnt <= 8'h00;
            vcnt <= 11'h000;
            raster <= '0;
        end else if (char_en) begin
            hcnt <= line_start ? 8'h00 : hcnt + 8'h01;
            if (frame_start) begin
                raster.field <= interlace && !raster.field;
                vcnt <= {10'h000, interlace && !raster.field};
            end else if (line_start) begin
                vcnt <= vcnt + vstep; // [R9]
            end
            raster.hsync <= (hcnt >= hsync_pos[`DLF_H_HI]) && (hcnt < hsync_pos[`DLF_H_LO]); // [R11]
            raster.vsync <= (vcnt >= vsync_pos[`DLF_V_HI]) && (vcnt < vsync_pos[`DLF_V_LO]);
            raster.blank <= (hcnt > htime[`DLF_H_LO]) || !line_active;
        end
    end

    // ------------------------------------------------------------------
    // Line pointers and burst fetch
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {DLF_IDLE, DLF_REQ, DLF_DATA} dlf_state_t;
    dlf_state_t state;
    logic [21:0] fb_ptr;
    logic [8:0] beat_cnt;
    logic [8:0] keep_qwords;

    assign keep_qwords = {1'b0, htime[`DLF_H_LO]};
    assign mem_req_valid = (state == DLF_REQ);

    // A line's burst starts only if the previous burst has drained; otherwise that line is skipped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= DLF_IDLE;
            mem_req <= '0;
            beat_cnt <= 9'h000;
        end else begin
            unique case (state)
                DLF_IDLE: begin
                    if (line_start && line_active && buffer_and_line_size[`DLF_FB_QWORDS] != 9'h0) begin
                        mem_req.addr <= frame_start ? fb_origin[`DLF_ORIGIN] : fb_ptr;
                        mem_req.qwords <= buffer_and_line_size[`DLF_FB_QWORDS]; // [R6]
                        state <= DLF_REQ;
                    end
                end
                DLF_REQ: begin
                    beat_cnt <= 9'h000;
                    if (mem_req_ready) begin
                        state <= DLF_DATA;
                    end
                end
                DLF_DATA: begin
                    if (mem_beat_valid) begin
                        beat_cnt <= beat_cnt + 9'h001;
                        if (beat_cnt == mem_req.qwords - 9'h001) begin
                            state <= DLF_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Pointers reload at frame start, then step by stride on each active line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fb_ptr <= 22'h0;
            cb_line_addr <= 22'h0;
        end else if (frame_start || !enable) begin
            // A stopped raster parks both pointers on the origins for the first frame
            fb_ptr <= fb_origin[`DLF_ORIGIN]; // [R14]
            cb_line_addr <= cb_origin[`DLF_ORIGIN]; // [R13] [R14]
        end else if (line_start && line_active) begin
            fb_ptr <= fb_ptr + {10'h0, line_stride[`DLF_FB_STRIDE], 2'b00}; // [R2]
            cb_line_addr <= cb_line_addr + {10'h0, line_stride[`DLF_CB_STRIDE], 2'b00}; // [R1]
        end
    end

    // Only the active width is passed on; panning surplus is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pix_valid <= 1'b0;
            pix_data <= 64'h0;
        end else begin
            pix_valid <= (state == DLF_DATA) && mem_beat_valid && beat_cnt <= keep_qwords; // [R7]
            if (mem_beat_valid) begin
                pix_data <= mem_beat_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Compressed FIFO overflow and interrupts
    // ------------------------------------------------------------------
    logic [6:0] cb_cnt, cb_len;
    logic cb_overflow;
    logic [31:0] size_wr;

    assign cb_len = buffer_and_line_size[`DLF_CB_LEN];
    // Length holds valid DWORDs plus one, so the len-th DWORD of a line overflows [R4] [R5]
    assign cb_overflow = cb_dword_valid && (cb_cnt + 7'h01 >= cb_len);
    assign video_buffer_bytes = {buffer_and_line_size[`DLF_VIDBUF_LEN], 6'h00}; // [R3]

    always_ff @(posedge aclk) begin
        if (!aresetn || line_start) begin
            cb_cnt <= 7'h00;
        end else if (cb_dword_valid && cb_cnt != 7'h7f) begin
            cb_cnt <= cb_cnt + 7'h01;
        end
    end

    assign irq_set[DLF_IRQ_OVF] = cb_overflow;
    assign irq_set[DLF_IRQ_FRAME] = frame_start;
    // Too long a length is flagged as it is written, even while the raster is stopped
    assign size_wr = merge(buffer_and_line_size);
    assign irq_set[DLF_IRQ_CFG] = wr_go && aw_addr == `DLF_BUF_SIZE_OFS
        && size_wr[`DLF_CB_LEN] > `DLF_CB_LEN_MAX; // [R5]

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (irq_set[i]) begin
                    irq_stat[i] <= 1'b1;
                end else if (wr_go && aw_addr == `DLF_IRQ_STAT_OFS && w_strb[0] && w_data[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(irq_stat & irq_mask[2:0]);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb_chk @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_frame_reload: assert property (frame_start |=> fb_ptr == fb_origin[`DLF_ORIGIN]) // [R14]
        else $error("frame pointer not reloaded");
    chk_fb_stride: assert property (line_start && line_active && !frame_start
        |=> fb_ptr == $past(fb_ptr) + {10'h0, $past(line_stride[`DLF_FB_STRIDE]), 2'b00}) // [R2]
        else $error("frame buffer stride wrong");
    chk_cb_stride: assert property (line_start && line_active && !frame_start
        |=> cb_line_addr == $past(cb_line_addr) + {10'h0, $past(line_stride[`DLF_CB_STRIDE]), 2'b00}) // [R1]
        else $error("compressed stride wrong");
    chk_drop_surplus: assert property (pix_valid |-> $past(beat_cnt) <= $past(keep_qwords)) // [R7]
        else $error("surplus qword passed");
    chk_qword_count: assert property ($rose(mem_req_valid)
        |-> mem_req.qwords == $past(buffer_and_line_size[`DLF_FB_QWORDS])) // [R6]
        else $error("burst length wrong");
    chk_overflow_flag: assert property (cb_overflow |=> irq_stat[DLF_IRQ_OVF]) // [R5]
        else $error("overflow not flagged");
    chk_char_period: assert property (char_en |=> !char_en [*7] ##1 (char_en || !enable)) // [R8]
        else $error("character clock not eight pixels");
    chk_interlace_step: assert property (line_start && interlace && !frame_start
        |=> vcnt == $past(vcnt) + 11'd2) // [R9]
        else $error("interlace step wrong");
    chk_vidbuf_size: assert property (##1 video_buffer_bytes[5:0] == 6'h00
        && video_buffer_bytes[19:6] == buffer_and_line_size[`DLF_VIDBUF_LEN]) // [R3]
        else $error("video buffer size wrong");

    cov_overflow: cover property (cb_overflow ##1 irq);
    cov_interlace_frame: cover property (frame_start && interlace);
    cov_dropped_beat: cover property (mem_beat_valid && state == DLF_DATA && beat_cnt > keep_qwords);
    cov_axi_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ==== verif/dlf_mem_model.sv ====
// Behavioural memory controller that answers burst read requests of the
// display line fetch block. Assumes one clock shared with the block.
`timescale 1ns/100ps
module dlf_mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic req_valid,
    input wire dlf_pkg::dlf_mem_req_t req,
    output logic req_ready,
    output logic beat_valid,
    output logic [63:0] beat_data
);
    import dlf_pkg::*;
    // ----------------------------------------------------------------
    // Request and beat sequencing
    // ----------------------------------------------------------------
    logic [21:0] base;
    logic [8:0] count;
    // Slow mode stalls before ready and between beats; idle data toggles
    // so a stale beat can never be mistaken for a fresh one
    initial begin
        req_ready = 1'b0;
        beat_valid = 1'b0;
        beat_data = 64'h0;
        forever begin
            @(posedge aclk);
            if (aresetn === 1'b1 && req_valid === 1'b1) begin
                if (slow) repeat (3) @(posedge aclk);
                req_ready <= 1'b1;
                base = req.addr;
                count = req.qwords;
                @(posedge aclk);
                req_ready <= 1'b0;
                for (int i = 0; i < count; i++) begin // Exactly the asked QWORDs
                    if (slow) begin
                        beat_valid <= 1'b0;
                        beat_data <= ~beat_data;
                        @(posedge aclk);
                    end
                    beat_valid <= 1'b1;
                    beat_data <= {base, 32'h0, 10'(i)};
                    @(posedge aclk);
                end
                beat_valid <= 1'b0;
                beat_data <= ~beat_data;
            end
        end
    end
endmodule

// ==== verif/dlf_line_fetch_bench.sv ====
// Self-checking bench of the display line fetch block: register table,
// line fetch, overflow interrupt and reset. Assumes the memory model file.
`timescale 1ns/100ps
`include "dlf_regs.svh"
module dlf_line_fetch_bench;
    import dlf_pkg::*;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    typedef struct {logic [15:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] rs;} dlf_row_t;
    logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, cb_dword_valid = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, mem_req_valid, mem_req_ready;
    logic mem_beat_valid, pix_valid, irq;
    logic [1:0] bresp, rresp, rs;
    logic [63:0] mem_beat_data, pix_data, last_pix;
    logic [21:0] cb_line_addr, prev_addr;
    logic [19:0] video_buffer_bytes;
    dlf_mem_req_t mem_req;
    dlf_raster_t raster;
    int failures = 0, comparisons = 0, cycles = 0, pix_cnt = 0, pix_seen = 0, vs_cnt = 0;
    dlf_row_t rows [16] = '{
        '{16'h8324, 32'hffff_ffff, 32'h003f_f3ff, 2'b00}, '{16'h8328, 32'hffff_ffff,
        32'h3fff_ffff, 2'b00}, '{16'h832c, 32'hffff_ffff, 32'h0, 2'b00},
        '{16'h8000, 32'hffff_ffff, 32'h0, 2'b10}, '{16'h838c, 32'h0, 32'h4, 2'b00},
        '{16'h838c, 32'h7, 32'h0, 2'b00}, '{16'h8324, 32'h0002_0040, 32'h0002_0040, 2'b00},
        '{16'h8328, 32'h0010_0806, 32'h0010_0806, 2'b00},
        '{16'h8330, 32'h01f8_0018, 32'h01f8_0018, 2'b00},
        '{16'h8334, 32'h0050_00a0, 32'h0050_00a0, 2'b00},
        '{16'h8338, 32'h0007_0003, 32'h0007_0003, 2'b00}, // Whole-frame lines
        '{16'h833c, 32'h0005_0006, 32'h0005_0006, 2'b00},
        '{16'h8384, 32'h0000_1007, 32'h0000_1000, 2'b00},
        '{16'h8380, 32'h0000_200f, 32'h0000_2000, 2'b00},
        '{16'h8390, 32'h1, 32'h1, 2'b00}, '{16'h8388, 32'h1, 32'h1, 2'b00}};
    // ----------------------------------------------------------------
    // Design, memory partner, clock, timeout
    // ----------------------------------------------------------------
    dlf_line_fetch uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_beat_valid(mem_beat_valid),
        .mem_beat_data(mem_beat_data), .pix_valid(pix_valid), .pix_data(pix_data),
        .cb_line_addr(cb_line_addr), .cb_dword_valid(cb_dword_valid),
        .video_buffer_bytes(video_buffer_bytes), .raster(raster), .irq(irq));
    dlf_mem_model mem0 (.aclk(aclk), .aresetn(aresetn), .slow(slow),
        .req_valid(mem_req_valid), .req(mem_req), .req_ready(mem_req_ready),
        .beat_valid(mem_beat_valid), .beat_data(mem_beat_data));
    always #20 aclk = ~aclk;
    // Kept pixels are tallied so each line's count can be judged later
    always @(posedge aclk) begin
        cycles++;
        if (raster.vsync === 1'b1) vs_cnt++;
        if (pix_valid === 1'b1) begin
            pix_cnt <= pix_cnt + 1;
            last_pix <= pix_data;
        end
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [15:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic pulse_dword();
        @(posedge aclk);
        cb_dword_valid <= 1'b1;
        @(posedge aclk);
        cb_dword_valid <= 1'b0;
    endtask
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // Table rows: write, answer code, read back with reserved bits cleared
        foreach (rows[i]) begin
            axi_wr(rows[i].a, rows[i].w);
            `CHK("bresp", rows[i].rs, rs)
            axi_rd(rows[i].a);
            `CHK("rresp", rows[i].rs, rs)
            `CHK("rdata", rows[i].r, rd)
        end
        `CHK("video_buffer_bytes", 20'h00400, video_buffer_bytes)
        $display("test registers done");
        // Six line requests span a frame wrap; later lines meet a slow memory
        for (int n = 0; n < 6; n++) begin
            do begin
                @(posedge aclk);
            end while (!(mem_req_valid === 1'b1 && mem_req_ready === 1'b1));
            slow <= (n >= 2);
            `CHK("mem_req.addr", 22'h1000 + 22'(n % 4) * 22'h100, mem_req.addr)
            `CHK("mem_req.qwords", 9'd6, mem_req.qwords)
            `CHK("cb_line_addr", 22'h2000 + 22'(n % 4 + 1) * 22'h80, cb_line_addr)
            `CHK("raster.blank", 1'b1, raster.blank)
            `CHK("raster.field", 1'b0, raster.field)
            if (n > 0) begin
                `CHK("kept qwords", 4, pix_cnt - pix_seen)
                `CHK("last pixel", {prev_addr, 32'h0, 10'd3}, last_pix)
            end
            pix_seen = pix_cnt;
            prev_addr = mem_req.addr;
            if (n == 1) begin
                repeat (3) pulse_dword();
                axi_rd(16'h838c);
                `CHK("overflow early", 1'b0, rd[0])
                pulse_dword();
                axi_rd(16'h838c);
                `CHK("overflow set", 1'b1, rd[0])
                `CHK("irq raised", 1'b1, irq)
                axi_wr(16'h8390, 32'h0);
                `CHK("irq masked", 1'b0, irq)
                axi_wr(16'h838c, 32'h1);
                axi_rd(16'h838c);
                `CHK("overflow cleared", 1'b0, rd[0])
                axi_wr(16'h8390, 32'h1);
            end
        end
        `CHK("vsync cycles", 512, vs_cnt)
        $display("test fetch done");
        // Reset in mid-run returns registers, mem_req_valid and irq to zero
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("mem_req_valid", 1'b0, mem_req_valid)
        `CHK("irq", 1'b0, irq)
        axi_rd(16'h8324);
        `CHK("line_stride", 32'h0, rd)
        axi_rd(16'h8328);
        `CHK("buffer_and_line_size", 32'h0, rd)
        $display("test reset done");
        complete_run();
    end
endmodule
